/* apc_defines.svh */
// Constants for the purge and write-protect command blocks.
`ifndef APC_DEFINES_SVH
`define APC_DEFINES_SVH
`define APC_CMD_PURGE 8'h82
`define APC_CMD_WPROT 8'hC2
`define APC_CMD_WRITE 8'h30
`define APC_CMD_SENSE 8'h03
`define APC_DH_MASK 8'hEF
`define APC_DH_PURGE 8'hA0
`define APC_DH_WPROT 8'hE0
`define APC_DH_OTHER 8'hA0
`define APC_DH_DRV_BIT 4
`define APC_SUB_ENABLE 8'h0C
`define APC_SUB_DISABLE 8'h0D
`define APC_SUB_PERM 8'h0F
`define APC_SUB_PW_ENABLE 8'h16
`define APC_SUB_PW_DISABLE 8'h17
`define APC_ERR_ABORT 8'h04
`define APC_SENSE_WP 8'h27
`define APC_NSEQ_RSVD 2'h3
`define APC_ID_WP_BIT 8
`define APC_BOOT_LOAD 2'h2
`define APC_BOOT_DONE 2'h3
`define APC_LFSR_SEED 8'hA5
`define APC_HR_FEAT 3'h0
`define APC_HR_SCNT 3'h1
`define APC_HR_SNUM 3'h2
`define APC_HR_CLO 3'h3
`define APC_HR_CHI 3'h4
`define APC_HR_DEV 3'h5
`define APC_HR_CMD 3'h6
`define APC_HR_STAT 3'h7
`define APC_STAT_BUSY 0
`define APC_STAT_ERR 1
`define APC_STAT_DONE 2
`endif

/* apc_pkg.sv */
// Types shared by the purge and write-protect command blocks.
package apc_pkg;
   // Write-protect states of the drive.
   typedef enum logic [1:0] {APC_WP_NORMAL, APC_WP_PROT, APC_WP_PASS, APC_WP_PERM} apc_wp_type;
   // Flash operation of one purge sequence, in field encoding order.
   typedef enum logic [1:0] {APC_OP_ERASE, APC_OP_RANDOM, APC_OP_PARAM1, APC_OP_PARAM2} apc_op_type;
   // Purge engine states.
   typedef enum logic [1:0] {APC_ENG_IDLE, APC_ENG_ISSUE, APC_ENG_WAIT} apc_eng_type;
   // Persistent purge progress, kept in non-volatile storage outside.
   typedef struct packed {
      logic active;
      logic dead;
      logic [7:0] opcode;
      logic [7:0] param1;
      logic [7:0] param2;
      logic [7:0] count;
      logic [7:0] rep;
      logic [1:0] seq;
   } apc_ctx_type;
endpackage : apc_pkg

/* apc_tf_if.sv */
// Task-file link between the host controller and the drive.
interface apc_tf_if;
   logic tf_valid;        // One-cycle command strobe from the host.
   logic [7:0] tf_cmd;    // Command register.
   logic [7:0] tf_feat;   // Features register.
   logic [7:0] tf_scnt;   // Sector count register.
   logic [7:0] tf_snum;   // Sector number register.
   logic [7:0] tf_clo;    // Cylinder low register.
   logic [7:0] tf_chi;    // Cylinder high register.
   logic [7:0] tf_dh;     // Drive/head register.
   logic tf_busy;         // Drive cannot take a command.
   logic tf_done;         // One-cycle completion pulse.
   logic tf_err;          // Error status, valid with tf_done.
   logic [7:0] tf_error;  // Error register, held until the drive takes the next command.
   modport host (output tf_valid, tf_cmd, tf_feat, tf_scnt, tf_snum, tf_clo, tf_chi, tf_dh,
                 input tf_busy, tf_done, tf_err, tf_error);
   modport device (input tf_valid, tf_cmd, tf_feat, tf_scnt, tf_snum, tf_clo, tf_chi, tf_dh,
                   output tf_busy, tf_done, tf_err, tf_error);
endinterface : apc_tf_if

/* apc_device.sv */
// Drive end: purge engine, write-protect state machine and command responses.
// Functional notes
// - Purge is command 82h with drive/head 101D0000.
// - Opcode bits 7:6 give one to three sequences.
// - Two-bit type field per sequence selects operation.
// - Features count repeats only sequence one.
// - All-zero parameters give one erase-only pass.
// - Purge erases everything; drive then unusable.
// - Purge progress persists and resumes after power-up.
// - After purge, ready status but no commands run.
// - Host may ask 8Eh/55h/AAh alternating purge.
// - Protection setting sampled only at power-on.
// - Protected writes complete cleanly, store nothing.
// - Request sense after discarded write reports 27h.
// - Write-protect command has no data phase.
// - Sub-functions 12,13,15,22,23; others reserved.
// - Password bytes 0-3 in features,snum,clo,chi.
// - Normal and protected state transitions per table.
// - Password state: 13 errors, 23 checks password.
// - Permanent state ignores every sub-function.
// - Identify word 129 bit 8 shows protection.
`include "apc_defines.svh"
module apc_device
   import apc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   apc_tf_if.device tf,
   input wire logic wp_jumper_in,
   input wire apc_wp_type nv_wp_state_in,
   input wire logic [31:0] nv_password_in,
   input wire apc_ctx_type nv_ctx_in,
   output apc_wp_type nv_wp_state_out,
   output logic [31:0] nv_password_out,
   output apc_ctx_type nv_ctx_out,
   output logic flash_op_valid_out,
   output apc_op_type flash_op_type_out,
   output logic [7:0] flash_op_pattern_out,
   input wire logic flash_op_done_in,
   output logic write_store_out,
   output logic [15:0] id_word129_out
);

   // Picks the two-bit operation field of a sequence out of the opcode.
   function automatic apc_op_type seq_type(input logic [7:0] opcode, input logic [1:0] seq);
      logic [1:0] field;
      field = 2'h0;
      case (seq)
         2'h0: field = opcode[1:0];
         2'h1: field = opcode[3:2];
         default: field = opcode[5:4];
      endcase
      return apc_op_type'(field);
   endfunction : seq_type

   logic jumper_meta;        // First synchroniser stage of the jumper pin.
   logic jumper_sync;        // Second stage, the only one logic reads.
   logic [1:0] boot_cnt;     // Counts edges after reset until the pin is settled.
   logic booted;             // Power-on sampling is over.
   apc_wp_type wp_state;     // Current protection state.
   logic [31:0] password;    // Password stored by the password enable.
   apc_ctx_type ctx;         // Live purge progress, mirrored to storage.
   apc_eng_type eng;         // Purge engine state.
   logic [7:0] lfsr;         // Random overwrite pattern source.
   logic fin;                // Purge completion pulse.
   logic resp_done;          // Completion pulse of ordinary commands.
   logic resp_err;           // Error status of the last completion.
   logic [7:0] resp_error;   // Error register contents.
   logic last_discard;       // Previous command was a discarded write.
   logic take;               // A command is accepted this cycle.
   logic is_purge;           // Command decodes as a purge.
   logic is_wprot;           // Command decodes as write-protect.
   logic purge_rsvd;         // Purge with the reserved sequence count.
   logic start_purge;        // Accepted, well-formed purge.
   apc_wp_type next_wp_state;
   logic wp_err;             // Sub-function answered with error.
   logic wp_rsvd;            // Sub-function code is reserved.
   logic [31:0] cmd_password;

   // The pin is asynchronous to the system clock, so it passes two flops first.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         jumper_meta <= 1'b0;
         jumper_sync <= 1'b0;
      end else if (ce_in) begin
         jumper_meta <= wp_jumper_in;
         jumper_sync <= jumper_meta;
      end
   end

   // Boot counter; commands are held off until the setting has been sampled.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         boot_cnt <= 2'h0;
      end else if (ce_in && !booted) begin
         boot_cnt <= boot_cnt + 2'h1;
      end
   end

   assign booted = (boot_cnt == `APC_BOOT_DONE);

   // Decode of the task file. Once the drive is purged nothing is accepted.
   always_comb begin
      is_purge = (tf.tf_cmd == `APC_CMD_PURGE) && ((tf.tf_dh & `APC_DH_MASK) == `APC_DH_PURGE);
      is_wprot = (tf.tf_cmd == `APC_CMD_WPROT) && ((tf.tf_dh & `APC_DH_MASK) == `APC_DH_WPROT);
      purge_rsvd = (tf.tf_scnt[7:6] == `APC_NSEQ_RSVD);
      take = ce_in && tf.tf_valid && booted && !ctx.active && !ctx.dead;
      start_purge = take && is_purge && !purge_rsvd;
   end

   // Sub-function decode against the current protection state.
   always_comb begin
      next_wp_state = wp_state;
      wp_err = 1'b0;
      wp_rsvd = 1'b0;
      cmd_password = {tf.tf_chi, tf.tf_clo, tf.tf_snum, tf.tf_feat};
      case (tf.tf_scnt)
         `APC_SUB_ENABLE: begin
            if (wp_state == APC_WP_NORMAL) begin
               next_wp_state = APC_WP_PROT;
            end
         end
         `APC_SUB_DISABLE: begin
            if (wp_state == APC_WP_PROT) begin
               next_wp_state = APC_WP_NORMAL;
            end else if (wp_state == APC_WP_PASS) begin
               wp_err = 1'b1;
            end
         end
         `APC_SUB_PERM: begin
            if (wp_state == APC_WP_NORMAL) begin
               next_wp_state = APC_WP_PERM;
            end
         end
         `APC_SUB_PW_ENABLE: begin
            if (wp_state == APC_WP_NORMAL) begin
               next_wp_state = APC_WP_PASS;
            end
         end
         `APC_SUB_PW_DISABLE: begin
            if (wp_state == APC_WP_PROT) begin
               next_wp_state = APC_WP_NORMAL;
            end else if (wp_state == APC_WP_PASS) begin
               if (cmd_password == password) begin
                  next_wp_state = APC_WP_NORMAL;
               end else begin
                  wp_err = 1'b1;
               end
            end
         end
         default: begin
            wp_rsvd = 1'b1;
         end
      endcase
   end

   // Protection state. It is loaded once at power-on; afterwards only commands move it.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         wp_state <= APC_WP_NORMAL;
         password <= 32'h0;
      end else if (ce_in) begin
         if (boot_cnt == `APC_BOOT_LOAD) begin
            // A closed jumper protects a drive that software left unprotected.
            wp_state <= (jumper_sync && nv_wp_state_in == APC_WP_NORMAL) ? APC_WP_PROT : nv_wp_state_in;
            password <= nv_password_in;
         end else if (take && is_wprot && !wp_rsvd && !wp_err) begin
            wp_state <= next_wp_state;
            if (wp_state == APC_WP_NORMAL && tf.tf_scnt == `APC_SUB_PW_ENABLE) begin
               password <= cmd_password;
            end
         end
      end
   end

   // Command answers, write discard and the sense code.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         resp_done <= 1'b0;
         resp_err <= 1'b0;
         resp_error <= 8'h00;
         last_discard <= 1'b0;
         write_store_out <= 1'b0;
      end else if (ce_in) begin
         resp_done <= take && !start_purge;
         write_store_out <= 1'b0;
         if (take) begin
            last_discard <= 1'b0;
            resp_err <= 1'b0;
            resp_error <= 8'h00;
            if (is_purge) begin
               // A reserved count is answered here with abort; a good purge answers at its end.
               resp_err <= purge_rsvd;
               resp_error <= purge_rsvd ? `APC_ERR_ABORT : 8'h00;
            end else if (is_wprot) begin
               // No sector transfer: the answer follows the command directly.
               resp_err <= wp_err || wp_rsvd;
               resp_error <= (wp_err || wp_rsvd) ? `APC_ERR_ABORT : 8'h00;
            end else if (tf.tf_cmd == `APC_CMD_WRITE) begin
               // A protected write still completes without error.
               write_store_out <= (wp_state == APC_WP_NORMAL);
               last_discard <= (wp_state != APC_WP_NORMAL);
            end else if (tf.tf_cmd == `APC_CMD_SENSE) begin
               resp_error <= last_discard ? `APC_SENSE_WP : 8'h00;
            end else begin
               resp_err <= 1'b1;
               resp_error <= `APC_ERR_ABORT;
            end
         end
      end
   end

   // Purge engine. Progress lives in ctx, which storage outside keeps across power loss.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         ctx <= '0;
         eng <= APC_ENG_IDLE;
         fin <= 1'b0;
         lfsr <= `APC_LFSR_SEED;
         flash_op_type_out <= APC_OP_ERASE;
         flash_op_pattern_out <= 8'h00;
      end else if (ce_in) begin
         fin <= 1'b0;
         if (boot_cnt == `APC_BOOT_LOAD) begin
            ctx <= nv_ctx_in;
         end else if (start_purge) begin
            // All-zero fields fall out as one erase-only sequence run once.
            ctx <= '{active: 1'b1, dead: 1'b0, opcode: tf.tf_scnt, param1: tf.tf_snum,
                     param2: tf.tf_clo, count: tf.tf_feat, rep: 8'h00, seq: 2'h0};
         end else begin
            case (eng)
               APC_ENG_IDLE: begin
                  if (booted && ctx.active) begin
                     eng <= APC_ENG_ISSUE;
                  end
               end
               APC_ENG_ISSUE: begin
                  flash_op_type_out <= seq_type(ctx.opcode, ctx.seq);
                  case (seq_type(ctx.opcode, ctx.seq))
                     APC_OP_RANDOM: flash_op_pattern_out <= lfsr;
                     APC_OP_PARAM1: flash_op_pattern_out <= ctx.param1;
                     APC_OP_PARAM2: flash_op_pattern_out <= ctx.param2;
                     default: flash_op_pattern_out <= 8'h00;
                  endcase
                  lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
                  eng <= APC_ENG_WAIT;
               end
               APC_ENG_WAIT: begin
                  if (flash_op_done_in) begin
                     eng <= APC_ENG_ISSUE;
                     if (ctx.seq == 2'h0 && ctx.rep != ctx.count) begin
                        ctx.rep <= ctx.rep + 8'h01;
                     end else if (ctx.seq != ctx.opcode[7:6]) begin
                        ctx.seq <= ctx.seq + 2'h1;
                     end else begin
                        // Firmware and tables are gone: the drive stays dead for good.
                        ctx.active <= 1'b0;
                        ctx.dead <= 1'b1;
                        fin <= 1'b1;
                        eng <= APC_ENG_IDLE;
                     end
                  end
               end
               default: eng <= APC_ENG_IDLE;
            endcase
         end
      end
   end

   // Identify word mirrors protection; any state but normal counts as protected.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         id_word129_out <= 16'h0000;
      end else if (ce_in) begin
         id_word129_out <= 16'h0000;
         id_word129_out[`APC_ID_WP_BIT] <= (wp_state != APC_WP_NORMAL);
      end
   end

   // A single flash operation covers every area, bad and reserve blocks included.
   assign flash_op_valid_out = (eng == APC_ENG_WAIT);
   assign tf.tf_busy = !booted || ctx.active;
   assign tf.tf_done = resp_done || fin;
   assign tf.tf_err = resp_err && !fin;
   assign tf.tf_error = fin ? 8'h00 : resp_error;
   assign nv_wp_state_out = wp_state;
   assign nv_password_out = password;
   assign nv_ctx_out = ctx;

endmodule : apc_device

/* apc_host.sv */
// Host end: software register port driving the drive's task file.
`include "apc_defines.svh"
module apc_host
   import apc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic [2:0] sw_addr_in,
   input wire logic [7:0] sw_wdata_in,
   input wire logic sw_wr_in,
   input wire logic sw_rd_in,
   output logic [7:0] sw_rdata_out,
   apc_tf_if.host tf
);

   logic [7:0] treg [0:5];  // Shadow task-file registers, by index.
   logic pending;           // A command is outstanding.
   logic done_flag;         // Sticky completion seen.
   logic err_flag;          // Error status of the last completion.
   logic [7:0] err_reg;     // Error register of the last completion.
   logic issue;             // Command write that is taken.
   logic [7:0] dh_base;     // Drive/head pattern for the command being written.

   // A command write while busy is dropped; software polls status first.
   assign issue = ce_in && sw_wr_in && (sw_addr_in == `APC_HR_CMD) && !pending && !tf.tf_busy;

   // Drive/head pattern fixed by the command code.
   always_comb begin
      case (sw_wdata_in)
         `APC_CMD_PURGE: dh_base = `APC_DH_PURGE;
         `APC_CMD_WPROT: dh_base = `APC_DH_WPROT;
         default: dh_base = `APC_DH_OTHER;
      endcase
   end

   // Shadow registers written by software.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < 6; i++) begin
            treg[i] <= 8'h00;
         end
      end else if (ce_in && sw_wr_in && sw_addr_in < `APC_HR_CMD) begin
         // Password bytes land in features, sector number and both cylinder registers.
         treg[sw_addr_in] <= sw_wdata_in;
      end
   end

   // Task-file strobe; the register contents ride with the command, no data phase.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         tf.tf_valid <= 1'b0;
         tf.tf_cmd <= 8'h00;
         tf.tf_feat <= 8'h00;
         tf.tf_scnt <= 8'h00;
         tf.tf_snum <= 8'h00;
         tf.tf_clo <= 8'h00;
         tf.tf_chi <= 8'h00;
         tf.tf_dh <= 8'h00;
      end else if (ce_in) begin
         tf.tf_valid <= issue;
         if (issue) begin
            tf.tf_cmd <= sw_wdata_in;
            tf.tf_feat <= treg[`APC_HR_FEAT];
            tf.tf_scnt <= treg[`APC_HR_SCNT];
            tf.tf_snum <= treg[`APC_HR_SNUM];
            tf.tf_clo <= treg[`APC_HR_CLO];
            tf.tf_chi <= treg[`APC_HR_CHI];
            tf.tf_dh <= dh_base | {3'h0, treg[`APC_HR_DEV][0], 4'h0};
         end
      end
   end

   // Completion tracking; a completion beats the clear from a new command.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         pending <= 1'b0;
         done_flag <= 1'b0;
         err_flag <= 1'b0;
         err_reg <= 8'h00;
      end else if (ce_in) begin
         if (tf.tf_done) begin
            pending <= 1'b0;
            done_flag <= 1'b1;
            err_flag <= tf.tf_err;
            err_reg <= tf.tf_error;
         end else if (issue) begin
            pending <= 1'b1;
            done_flag <= 1'b0;
         end
      end
   end

   // Read data one cycle after the strobe, zero otherwise.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         sw_rdata_out <= 8'h00;
      end else if (ce_in) begin
         sw_rdata_out <= 8'h00;
         if (sw_rd_in) begin
            case (sw_addr_in)
               `APC_HR_CMD: sw_rdata_out <= err_reg;
               `APC_HR_STAT: sw_rdata_out <= {5'h00, done_flag, err_flag, pending | tf.tf_busy};
               default: sw_rdata_out <= treg[sw_addr_in];
            endcase
         end
      end
   end

endmodule : apc_host

/* apc_tf_properties.sv */
// Concurrent checks on the task-file link of the two ends.
`include "apc_defines.svh"
module apc_tf_properties (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic tf_valid,
   input wire logic [7:0] tf_cmd,
   input wire logic [7:0] tf_scnt,
   input wire logic [7:0] tf_dh,
   input wire logic tf_busy,
   input wire logic tf_done,
   input wire logic tf_err,
   input wire logic [7:0] tf_error
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in);
   logic taken; // A command the drive must act on.
   logic purge_cmd; // A purge request with its drive/head pattern.
   logic good_purge; // A purge with a legal count.
   logic wp_cmd; // A write-protect request.
   logic purge_run; // A purge has been started.
   logic dead; // The purge is over; the drive stays silent.
   assign taken = tf_valid && !tf_busy && !dead;
   assign purge_cmd = taken && tf_cmd == `APC_CMD_PURGE && (tf_dh & `APC_DH_MASK) == `APC_DH_PURGE;
   assign good_purge = purge_cmd && tf_scnt[7:6] != `APC_NSEQ_RSVD;
   assign wp_cmd = taken && tf_cmd == `APC_CMD_WPROT && (tf_dh & `APC_DH_MASK) == `APC_DH_WPROT;
   // Tracks purge progress; its completion is the drive's last answer.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         purge_run <= 1'b0;
         dead <= 1'b0;
      end else begin
         if (good_purge) begin
            purge_run <= 1'b1;
         end
         if (purge_run && tf_done) begin
            dead <= 1'b1;
         end
      end
   end
   done_pulse_a : assert property (tf_done |=> !tf_done)
      else $error("done pulse too long");
   cmd_answer_a : assert property (taken && !good_purge |=> tf_done)
      else $error("command not answered");
   write_ok_a : assert property (taken && tf_cmd == `APC_CMD_WRITE |=> tf_done && !tf_err)
      else $error("write gave error");
   sense_code_a : assert property (taken && tf_cmd == `APC_CMD_SENSE |=> !tf_err &&
      (tf_error == 8'h00 || tf_error == `APC_SENSE_WP)) else $error("bad sense code");
   wp_abort_a : assert property (wp_cmd && !(tf_scnt inside {`APC_SUB_ENABLE, `APC_SUB_DISABLE, `APC_SUB_PERM,
      `APC_SUB_PW_ENABLE, `APC_SUB_PW_DISABLE}) |=> tf_err && tf_error == `APC_ERR_ABORT)
      else $error("reserved code not aborted");
   purge_rsvd_a : assert property (purge_cmd && tf_scnt[7:6] == `APC_NSEQ_RSVD |=>
      tf_done && tf_err && tf_error == `APC_ERR_ABORT) else $error("reserved count not aborted");
   purge_busy_a : assert property (good_purge |=> tf_busy && !tf_done)
      else $error("purge not started");
   purge_hold_a : assert property (purge_run && !dead && !tf_done |-> tf_busy)
      else $error("not busy while purging");
   dead_silent_a : assert property (dead |-> !tf_done && !tf_busy)
      else $error("dead drive not silent and ready");
   cover property (good_purge);
   cover property (wp_cmd && tf_scnt == `APC_SUB_PW_DISABLE ##1 tf_err);
   cover property (dead && tf_valid);
endmodule : apc_tf_properties

/* apc_tb_top.sv */
// Bench joining the host and drive ends, with a prompt flash responder.
`include "apc_defines.svh"
module apc_tb_top;
   import apc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [2:0] sw_addr_in = 3'h0;
   logic [7:0] sw_wdata_in = 8'h00;
   logic sw_wr_in = 1'b0;
   logic sw_rd_in = 1'b0;
   logic wp_jumper_in = 1'b1; // Closed from power-on.
   logic flash_op_done_in = 1'b0;
   logic [7:0] sw_rdata_out;
   logic flash_op_valid_out;
   logic write_store_out;
   apc_wp_type wp_state; // Live protection state.
   apc_op_type op_type;
   logic [7:0] op_pat;
   logic [15:0] id_word;
   logic last_err; // Error flag of the last command.
   logic [7:0] last_error; // Error register after the last command.
   logic [9:0] ops[$]; // Flash operations seen, type over pattern.
   int n_fail = 0;
   int tests_run = 0;
   int n_store = 0; // Write store pulses seen.
   localparam logic [31:0] PW = 32'h5A3C_96E1;
   apc_tf_if u_apc_tf_if ();
   apc_host u_apc_host (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .sw_addr_in(sw_addr_in),
      .sw_wdata_in(sw_wdata_in), .sw_wr_in(sw_wr_in), .sw_rd_in(sw_rd_in), .sw_rdata_out(sw_rdata_out),
      .tf(u_apc_tf_if));
   apc_device u_apc_device (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .tf(u_apc_tf_if),
      .wp_jumper_in(wp_jumper_in), .nv_wp_state_in(APC_WP_NORMAL), .nv_password_in(32'h0),
      .nv_ctx_in('0), .nv_wp_state_out(wp_state), .nv_password_out(), .nv_ctx_out(),
      .flash_op_valid_out(flash_op_valid_out), .flash_op_type_out(op_type), .flash_op_pattern_out(op_pat),
      .flash_op_done_in(flash_op_done_in), .write_store_out(write_store_out), .id_word129_out(id_word));
   apc_tf_properties u_apc_tf_properties (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .tf_valid(u_apc_tf_if.tf_valid), .tf_cmd(u_apc_tf_if.tf_cmd), .tf_scnt(u_apc_tf_if.tf_scnt),
      .tf_dh(u_apc_tf_if.tf_dh), .tf_busy(u_apc_tf_if.tf_busy), .tf_done(u_apc_tf_if.tf_done),
      .tf_err(u_apc_tf_if.tf_err), .tf_error(u_apc_tf_if.tf_error));
   // The clock runs at 40 MHz.
   always #12.5 clk_sys_in = ~clk_sys_in;
   // Ends each flash operation a cycle after it starts and logs it.
   always @(posedge clk_sys_in) begin
      if (flash_op_valid_out && flash_op_done_in) begin
         ops.push_back({op_type, op_pat});
      end
      flash_op_done_in <= flash_op_valid_out && !flash_op_done_in;
   end
   // Counts writes let through to flash.
   always @(posedge clk_sys_in) begin
      if (write_store_out === 1'b1) begin
         n_store <= n_store + 1;
      end
   end
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      sw_addr_in <= a;
      sw_wdata_in <= d;
      sw_wr_in <= 1'b1;
      @(posedge clk_sys_in);
      sw_wr_in <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe; take them just past its edge.
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_sys_in);
      sw_addr_in <= a;
      sw_rd_in <= 1'b1;
      @(posedge clk_sys_in);
      sw_rd_in <= 1'b0;
      #1 d = sw_rdata_out;
   endtask : rd
   // Loads the task file, issues a command and polls for its completion.
   task automatic cmd(input logic [7:0] c, input logic [7:0] sc, input logic [31:0] pw, input logic want);
      logic [7:0] s;
      wr(3'h0, pw[7:0]);
      wr(3'h1, sc);
      wr(3'h2, pw[15:8]);
      wr(3'h3, pw[23:16]);
      wr(3'h4, pw[31:24]);
      wr(3'h6, c);
      s = 8'h00;
      for (int i = 0; i < 400 && s[2] !== 1'b1; i++) rd(3'h7, s);
      check("done", s[2], want);
      if (s[2] !== want) wrap_up();
      last_err = s[1];
      rd(3'h6, last_error);
   endtask : cmd
   task automatic wp(input logic [7:0] sub, input logic [31:0] pw, input logic err, input apc_wp_type st);
      cmd(`APC_CMD_WPROT, sub, pw, 1'b1);
      check("wp_err", last_err, err);
      check("wp_state", wp_state, st);
      check("id_bit8", id_word[`APC_ID_WP_BIT], st != APC_WP_NORMAL);
      if (err) check("wp_code", last_error, `APC_ERR_ABORT);
   endtask : wp
   task automatic sc_plain;
      int s0;
      wp(`APC_SUB_DISABLE, 32'h0, 1'b0, APC_WP_NORMAL);
      s0 = n_store;
      cmd(`APC_CMD_WRITE, 8'h01, 32'h0, 1'b1);
      check("wr_err", last_err, 1'b0);
      check("wr_store", n_store, s0 + 1);
      wp(`APC_SUB_DISABLE, 32'h0, 1'b0, APC_WP_NORMAL);
      wp(`APC_SUB_ENABLE, 32'h0, 1'b0, APC_WP_PROT);
      wp(`APC_SUB_PERM, 32'h0, 1'b0, APC_WP_PROT);
      wp(`APC_SUB_DISABLE, 32'h0, 1'b0, APC_WP_NORMAL);
      wp(`APC_SUB_ENABLE, 32'h0, 1'b0, APC_WP_PROT);
      wp(`APC_SUB_PW_DISABLE, 32'h0, 1'b0, APC_WP_NORMAL);
   endtask : sc_plain
   task automatic sc_password;
      int s0;
      wp(`APC_SUB_PW_ENABLE, PW, 1'b0, APC_WP_PASS);
      wp(`APC_SUB_DISABLE, 32'h0, 1'b1, APC_WP_PASS);
      wp(`APC_SUB_ENABLE, PW, 1'b0, APC_WP_PASS);
      wp(`APC_SUB_PW_DISABLE, PW ^ 32'h0100_0000, 1'b1, APC_WP_PASS);
      s0 = n_store;
      cmd(`APC_CMD_WRITE, 8'h01, 32'h0, 1'b1);
      check("pwr_err", last_err, 1'b0);
      check("pwr_store", n_store, s0);
      cmd(`APC_CMD_SENSE, 8'h00, 32'h0, 1'b1);
      check("sense_code", last_error, `APC_SENSE_WP);
      wp(8'h0E, PW, 1'b1, APC_WP_PASS);
      wp(`APC_SUB_PW_DISABLE, PW, 1'b0, APC_WP_NORMAL);
      wp(`APC_SUB_PERM, 32'h0, 1'b0, APC_WP_PERM);
      wp(`APC_SUB_DISABLE, 32'h0, 1'b0, APC_WP_PERM);
      wp(`APC_SUB_PW_DISABLE, PW, 1'b0, APC_WP_PERM);
   endtask : sc_password
   // Three sequences: parameter one twice, parameter two, then a plain erase.
   task automatic sc_purge;
      logic [9:0] exp_ops[4];
      exp_ops = '{{APC_OP_PARAM1, 8'h55}, {APC_OP_PARAM1, 8'h55}, {APC_OP_PARAM2, 8'hAA}, {APC_OP_ERASE, 8'h00}};
      cmd(`APC_CMD_PURGE, 8'hC0, 32'h0, 1'b1);
      check("rsvd_err", last_err, 1'b1);
      check("rsvd_ops", ops.size(), 0);
      cmd(`APC_CMD_PURGE, 8'h8E, {8'h00, 8'hAA, 8'h55, 8'h01}, 1'b1);
      check("purge_err", last_err, 1'b0);
      check("purge_ops", ops.size(), 4);
      for (int i = 0; i < 4 && i < ops.size(); i++) begin
         check("op_type", ops[i][9:8], exp_ops[i][9:8]);
         if (i < 3) check("op_pat", ops[i][7:0], exp_ops[i][7:0]);
      end
      cmd(`APC_CMD_WRITE, 8'h01, 32'h0, 1'b0);
   endtask : sc_purge
   initial begin
      repeat (6) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      repeat (5) @(posedge clk_sys_in);
      check("boot_wp", wp_state, APC_WP_PROT);
      sc_plain();
      sc_password();
      sc_purge();
      wrap_up();
   end
endmodule : apc_tb_top
